// ==== rtl/sar_conversion_control.sv ====
// Conversion sequencer, result register and serial readout of the converter.
// Assumes pins arrive asynchronously and the comparator output is a pin.
//
// Function
// - Trigger rising edge ends acquisition and starts a conversion.
// - Open input ground switches first, then move both arrays to ground.
// - Convert the differential sample held when acquisition ended.
// - Eighteen decisions from the MSB, weights halving down to one LSB.
// - After the last decision, return to acquisition and form the code.
// - Internal conversion clock times conversion; serial clock unused.
// - The result belongs to the conversion just finished, no latency.
// - Fast variant sustains 500k, slow 100k conversions per second.
// - Power down automatically between conversions.
// - Results are 18-bit two's-complement codes around midscale zero.
// - Overrange input saturates at the positive maximum code.
// - Underrange input saturates at the most negative code.
// - Latch the mode input at trigger rise: low chain, high select.
// - Readout gives MSB first, next bits on serial clock falling edges.
`timescale 1ns/1ps
module sar_conversion_control #(
  parameter int W         = 18,
  parameter int DIV       = sar_pkg::CONV_DIV,
  parameter bit FAST_PART = 1'b1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         conversion_trigger,
  input  wire logic         mode_select_chain_input,
  input  wire logic         sclk,
  input  wire logic         comparator_out,
  input  wire logic         overrange_detect,
  input  wire logic         underrange_detect,
  output logic              positive_input_ground_switch,
  output logic              negative_input_ground_switch,
  output logic              array_to_ground,
  output logic [W-1:0]      dac_trial,
  output logic              converting,
  output logic              powered_down,
  output logic              chain_mode,
  output logic [W-1:0]      result_code,
  output logic              result_ready,
  output logic              serial_result_output,
  output logic              serial_result_oe_n
);

  localparam int PERIOD_CYC = FAST_PART ? sar_pkg::FAST_PERIOD_CYC
                                        : sar_pkg::SLOW_PERIOD_CYC;
  localparam int CONV_CYC   = (sar_pkg::SETUP_TICKS + W + 1) * DIV + 2;
  localparam int CNT_W      = $clog2(W + 1);
  localparam int DIV_W      = $clog2(DIV + 1);
  localparam int CONV_BOUND = 80;

  localparam logic [CNT_W-1:0] BITS_OUT = CNT_W'(W);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);

  initial begin
    if (W != sar_pkg::RES_BITS) $error("Resolution must be 18 bits.");
    // Each decision waits for the comparator to cross both sync flops.
    if (DIV < 3) $error("Divide ratio must cover the comparator flops.");
    if (CONV_CYC > PERIOD_CYC) $error("Conversion too slow for rate.");
    if (CONV_CYC > CONV_BOUND) $error("Conversion exceeds checked bound.");
  end

  sar_if #(.W(W)) sbus ();

  sar_register #(.W(W)) u_sar (
    .clk  (clk),
    .nrst (nrst),
    .bus  (sbus)
  );

  // Two-flop synchronisers for all pin inputs.
  logic [sar_pkg::PIN_COUNT-1:0] pins_meta;
  logic [sar_pkg::PIN_COUNT-1:0] pins_sync;
  logic [sar_pkg::PIN_COUNT-1:0] pins_raw;

  assign pins_raw = {underrange_detect, overrange_detect, comparator_out,
                     sclk, mode_select_chain_input, conversion_trigger};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pins_meta <= '0;
      pins_sync <= '0;
    end else begin
      pins_meta <= pins_raw;
      pins_sync <= pins_meta;
    end
  end

  logic trig_prev;
  logic sclk_prev;
  logic trig_s;
  logic mode_s;
  logic sclk_s;
  logic trig_rise;
  logic sclk_fall;

  assign trig_s    = pins_sync[sar_pkg::PIN_TRIG];
  assign mode_s    = pins_sync[sar_pkg::PIN_MODE];
  assign sclk_s    = pins_sync[sar_pkg::PIN_SCLK];
  assign trig_rise = trig_s & ~trig_prev;
  assign sclk_fall = ~sclk_s & sclk_prev;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      trig_prev <= 1'b0;
      sclk_prev <= 1'b0;
    end else begin
      trig_prev <= trig_s;
      sclk_prev <= sclk_s;
    end
  end

  // Internal conversion clock: one tick every DIV cycles while converting.
  sar_pkg::phase_t   phase;
  sar_pkg::phase_t   next_phase;
  logic [DIV_W-1:0]  div_cnt;
  logic              tick;
  logic              acquiring;
  logic              start_conv;

  assign acquiring  = (phase == sar_pkg::ST_ACQUIRE);
  assign start_conv = acquiring & trig_rise;
  assign tick       = !acquiring && div_cnt == DIV_LAST;

  always_ff @(posedge clk) begin
    if (!nrst || acquiring) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= tick ? '0 : div_cnt + 1'b1;
    end
  end

  always_comb begin
    next_phase = phase;
    unique case (phase)
      sar_pkg::ST_ACQUIRE:   if (start_conv) next_phase = sar_pkg::ST_OPEN_SW;
      sar_pkg::ST_OPEN_SW:   if (tick) next_phase = sar_pkg::ST_ARRAY_GND;
      sar_pkg::ST_ARRAY_GND: if (tick) next_phase = sar_pkg::ST_DECIDE;
      sar_pkg::ST_DECIDE:    if (sbus.done) next_phase = sar_pkg::ST_FINISH;
      sar_pkg::ST_FINISH:    next_phase = sar_pkg::ST_ACQUIRE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase <= sar_pkg::ST_ACQUIRE;
    end else begin
      phase <= next_phase;
    end
  end

  // Switch control, power state and latched mode.
  logic over_held;
  logic under_held;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      positive_input_ground_switch <= 1'b1;
      negative_input_ground_switch <= 1'b1;
      array_to_ground              <= 1'b0;
      converting                   <= 1'b0;
      powered_down                 <= 1'b1;
      chain_mode                   <= 1'b0;
      over_held                    <= 1'b0;
      under_held                   <= 1'b0;
    end else begin
      if (start_conv) begin
        positive_input_ground_switch <= 1'b0;
        negative_input_ground_switch <= 1'b0;
        converting                   <= 1'b1;
        powered_down                 <= 1'b0;
        chain_mode                   <= ~mode_s;
      end
      if (phase == sar_pkg::ST_OPEN_SW && tick) begin
        array_to_ground <= 1'b1;
        over_held       <= pins_sync[sar_pkg::PIN_OVER];
        under_held      <= pins_sync[sar_pkg::PIN_UNDER];
      end
      if (phase == sar_pkg::ST_FINISH) begin
        positive_input_ground_switch <= 1'b1;
        negative_input_ground_switch <= 1'b1;
        array_to_ground              <= 1'b0;
        converting                   <= 1'b0;
        powered_down                 <= 1'b1;
      end
    end
  end

  // Drive of the approximation register.
  assign sbus.start = phase == sar_pkg::ST_ARRAY_GND && tick;
  assign sbus.step  = phase == sar_pkg::ST_DECIDE && tick;
  assign sbus.cmp   = pins_sync[sar_pkg::PIN_CMP];
  assign dac_trial  = sbus.trial;

  // Result register with saturation on out-of-range samples.
  logic [W-1:0] clamped_code;

  assign clamped_code = over_held  ? sar_pkg::CODE_POS_MAX
                      : under_held ? sar_pkg::CODE_NEG_MIN
                      : sbus.code;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      result_code  <= sar_pkg::RESULT_RESET;
      result_ready <= 1'b0;
    end else begin
      result_ready <= phase == sar_pkg::ST_FINISH;
      if (phase == sar_pkg::ST_FINISH) begin
        result_code <= clamped_code;
      end
    end
  end

  // Serial readout, only during acquisition after the result is ready.
  logic [W-1:0]     shifter;
  logic [CNT_W-1:0] bits_sent;
  logic             read_enable;
  logic             shifting;

  assign read_enable = acquiring && !result_ready &&
                       (chain_mode ? trig_s : (!trig_s || !mode_s));
  assign shifting    = read_enable && sclk_fall && bits_sent != BITS_OUT;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      shifter   <= sar_pkg::RESULT_RESET;
      bits_sent <= '0;
    end else if (phase == sar_pkg::ST_FINISH) begin
      shifter   <= clamped_code;
      bits_sent <= '0;
    end else if (shifting) begin
      shifter   <= {shifter[W-2:0], chain_mode & mode_s};
      bits_sent <= bits_sent + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      serial_result_output <= 1'b0;
      serial_result_oe_n   <= 1'b1;
    end else begin
      serial_result_output <= shifting ? shifter[W-2] : shifter[W-1];
      serial_result_oe_n   <= !(read_enable &&
                               (bits_sent + CNT_W'(shifting)) != BITS_OUT);
    end
  end

  sequence seq_trigger_taken;
    acquiring && trig_rise;
  endsequence

  sequence seq_switch_order;
    !positive_input_ground_switch ##1 !positive_input_ground_switch[*1]
      ##[1:8] array_to_ground;
  endsequence

  AST_TRIG_STARTS: assert property (
    @(posedge clk) disable iff (!nrst)
    seq_trigger_taken |=> phase == sar_pkg::ST_OPEN_SW && converting)
    else $error("Trigger rise did not start a conversion.");

  AST_SWITCH_ORDER: assert property (
    @(posedge clk) disable iff (!nrst)
    seq_trigger_taken |=> seq_switch_order)
    else $error("Arrays moved to ground before switches opened.");

  AST_ARRAY_NEEDS_OPEN: assert property (
    @(posedge clk) disable iff (!nrst)
    $rose(array_to_ground) |-> !$past(negative_input_ground_switch))
    else $error("Sample not held when arrays were grounded.");

  AST_CONV_BOUND: assert property (
    @(posedge clk) disable iff (!nrst)
    $rose(converting) |-> ##[1:CONV_BOUND] !converting)
    else $error("Conversion exceeded its time budget.");

  AST_IGNORE_TRIG: assert property (
    @(posedge clk) disable iff (!nrst)
    (converting && trig_rise) |=> $stable(chain_mode)
      && (converting || result_ready))
    else $error("Trigger rise disturbed a running conversion.");

  AST_MODE_LATCH: assert property (
    @(posedge clk) disable iff (!nrst)
    seq_trigger_taken |=> chain_mode == !$past(mode_s))
    else $error("Mode input not latched at trigger rise.");

  AST_POWER_DOWN: assert property (
    @(posedge clk) disable iff (!nrst)
    phase == sar_pkg::ST_FINISH |=> powered_down && acquiring
      && positive_input_ground_switch)
    else $error("Device did not return to powered-down acquisition.");

  AST_RESULT_HOLD: assert property (
    @(posedge clk) disable iff (!nrst)
    !result_ready |-> $stable(result_code))
    else $error("Result changed without a finished conversion.");

  AST_CLAMP_POS: assert property (
    @(posedge clk) disable iff (!nrst)
    (phase == sar_pkg::ST_FINISH && over_held)
      |=> result_code == sar_pkg::CODE_POS_MAX)
    else $error("Overrange did not saturate positive.");

  AST_CLAMP_NEG: assert property (
    @(posedge clk) disable iff (!nrst)
    (phase == sar_pkg::ST_FINISH && !over_held && under_held)
      |=> result_code == sar_pkg::CODE_NEG_MIN)
    else $error("Underrange did not saturate negative.");

  AST_SAME_CONV: assert property (
    @(posedge clk) disable iff (!nrst)
    (phase == sar_pkg::ST_FINISH && !over_held && !under_held)
      |=> result_code == $past(sbus.code) && result_ready)
    else $error("Result is not from the conversion just done.");

  AST_SHIFT_MSB: assert property (
    @(posedge clk) disable iff (!nrst)
    shifting |=> serial_result_output == $past(shifter[W-2]))
    else $error("Serial output did not advance on falling edge.");

endmodule

// ==== rtl/sar_pkg.sv ====
// Constants, timing figures and state type for the conversion control.
// Assumes a single 40 MHz clock; nothing here holds logic.
package sar_pkg;

  localparam int RES_BITS = 18;

  localparam logic [17:0] CODE_POS_MAX = 18'h1FFFF;
  localparam logic [17:0] CODE_NEG_MIN = 18'h20000;
  localparam logic [17:0] CODE_MID     = 18'h00000;
  localparam logic [17:0] RESULT_RESET = 18'h00000;

  localparam int CLK_PERIOD_NS = 25;

  // Shortest sample period of each variant, in nanoseconds.
  localparam int FAST_PERIOD_NS = 2000;
  localparam int SLOW_PERIOD_NS = 10000;
  localparam int FAST_RATE_SPS  = 500_000;
  localparam int SLOW_RATE_SPS  = 100_000;

  // Shortest periods round down to whole clock cycles.
  localparam int FAST_PERIOD_CYC = FAST_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SLOW_PERIOD_CYC = SLOW_PERIOD_NS / CLK_PERIOD_NS;

  // Internal conversion clock divide ratio and its sequence length.
  localparam int CONV_DIV    = 3;
  localparam int SETUP_TICKS = 2;

  // Pin positions in the synchroniser vector.
  localparam int PIN_TRIG  = 0;
  localparam int PIN_MODE  = 1;
  localparam int PIN_SCLK  = 2;
  localparam int PIN_CMP   = 3;
  localparam int PIN_OVER  = 4;
  localparam int PIN_UNDER = 5;
  localparam int PIN_COUNT = 6;

  typedef enum {
    ST_ACQUIRE,
    ST_OPEN_SW,
    ST_ARRAY_GND,
    ST_DECIDE,
    ST_FINISH
  } phase_t;

endpackage

// ==== rtl/sar_if.sv ====
// Carrier between the sequencer and the approximation register.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface sar_if #(
  parameter int W = 18
);
  logic         start;
  logic         step;
  logic         cmp;
  logic         done;
  logic [W-1:0] trial;
  logic [W-1:0] code;

  modport ctrl (output start, output step, output cmp,
                input done, input trial, input code);
  modport sar  (input start, input step, input cmp,
                output done, output trial, output code);
endinterface

// ==== rtl/sar_register.sv ====
// Successive-approximation register: trial weights and decisions.
// Assumes one step pulse per conversion clock tick, cmp valid with it.
`timescale 1ns/1ps
module sar_register #(
  parameter int W = 18
) (
  input  wire logic clk,
  input  wire logic nrst,
  sar_if.sar        bus
);

  logic [W-1:0] mask;
  logic [W-1:0] next_trial;
  logic         last_bit;

  initial begin
    if (W < 2) $error("Resolution too small.");
  end

  assign last_bit   = mask[0];
  assign next_trial = (bus.cmp ? bus.trial : bus.trial & ~mask)
                      | (mask >> 1);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      bus.trial <= '0;
      mask      <= '0;
      bus.done  <= 1'b0;
      bus.code  <= '0;
    end else begin
      bus.done <= 1'b0;
      if (bus.start) begin
        bus.trial <= {1'b1, {(W-1){1'b0}}};
        mask      <= {1'b1, {(W-1){1'b0}}};
      end else if (bus.step && mask != '0) begin
        bus.trial <= next_trial;
        mask      <= mask >> 1;
        if (last_bit) begin
          bus.done <= 1'b1;
          bus.code <= {~next_trial[W-1], next_trial[W-2:0]};
        end
      end
    end
  end

  AST_MSB_FIRST: assert property (
    @(posedge clk) disable iff (!nrst)
    bus.start |=> bus.trial == {1'b1, {(W-1){1'b0}}} && mask[W-1])
    else $error("First trial is not the top bit.");

  AST_TWOS_CODE: assert property (
    @(posedge clk) disable iff (!nrst)
    (bus.step && last_bit && !bus.start) |=>
      bus.done && bus.code[W-1] == ~bus.trial[W-1])
    else $error("Output code is not two's complement of decisions.");

endmodule

// ==== verification/analog_front_model.sv ====
// Behavioural analog side: holds the input sample and answers each trial.
// Assumes the ground switch opens once per conversion, when sampling ends.
`timescale 1ns/1ps
module analog_front_model #(
  parameter int W = 18
) (
  input  wire logic         ground_switch,
  input  wire logic [W-1:0] dac_trial,
  input  wire logic [W-1:0] live_value,
  input  wire logic         live_over,
  input  wire logic         live_under,
  output logic              comparator_out,
  output logic              overrange_detect,
  output logic              underrange_detect
);
  logic [W-1:0] held;
  logic [W-1:0] msb;

  assign msb = {1'b1, {(W-1){1'b0}}};

  initial begin
    held = '0;
    overrange_detect = 1'b0;
    underrange_detect = 1'b0;
  end

  // The sample freezes when the switch opens; later input moves are unseen.
  always @(negedge ground_switch) begin
    held = live_value;
    overrange_detect = live_over;
    underrange_detect = live_under;
  end

  // A trial at or below the held level keeps its bit.
  assign comparator_out = (dac_trial <= (held ^ msb));
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the conversion control block.
// Assumes the analog model on the comparator side and a 40 MHz clock.
`timescale 1ns/1ps
module tb;
  localparam int W        = 18;
  localparam int WDOG_CYC = 20000;

  logic         clk;
  logic         nrst;
  logic         conversion_trigger;
  logic         mode_select_chain_input;
  logic         sclk;
  logic         comparator_out;
  logic         overrange_detect;
  logic         underrange_detect;
  logic         positive_input_ground_switch;
  logic         negative_input_ground_switch;
  logic         array_to_ground;
  logic [W-1:0] dac_trial;
  logic         converting;
  logic         powered_down;
  logic         chain_mode;
  logic [W-1:0] result_code;
  logic         result_ready;
  logic         serial_result_output;
  logic         serial_result_oe_n;
  logic [W-1:0] live_value;
  logic         live_over;
  logic         live_under;
  int           n_errors;
  int           compares;
  int           n_ready;
  logic [W-1:0] vals [6];

  sar_conversion_control #(
    .W(W), .DIV(sar_pkg::CONV_DIV), .FAST_PART(1'b1)
  ) dut_u (
    .clk(clk), .nrst(nrst), .conversion_trigger(conversion_trigger),
    .mode_select_chain_input(mode_select_chain_input), .sclk(sclk),
    .comparator_out(comparator_out), .overrange_detect(overrange_detect),
    .underrange_detect(underrange_detect),
    .positive_input_ground_switch(positive_input_ground_switch),
    .negative_input_ground_switch(negative_input_ground_switch),
    .array_to_ground(array_to_ground), .dac_trial(dac_trial),
    .converting(converting), .powered_down(powered_down),
    .chain_mode(chain_mode), .result_code(result_code),
    .result_ready(result_ready), .serial_result_output(serial_result_output),
    .serial_result_oe_n(serial_result_oe_n));

  analog_front_model #(.W(W)) front_u (
    .ground_switch(positive_input_ground_switch), .dac_trial(dac_trial),
    .live_value(live_value), .live_over(live_over),
    .live_under(live_under), .comparator_out(comparator_out),
    .overrange_detect(overrange_detect),
    .underrange_detect(underrange_detect));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (result_ready === 1'b1) n_ready++;
  end

  task automatic chk1(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk18(input string what, input logic [W-1:0] exp,
                       input logic [W-1:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One conversion; the input moves after the hold point to prove the hold.
  task automatic convert(input logic [W-1:0] val, input logic ov,
                         input logic un, input logic bounce,
                         input logic [W-1:0] exp);
    int t;
    int first;
    conversion_trigger = 1'b0;
    live_value = val;
    live_over = ov;
    live_under = un;
    cycles(4);
    first = n_ready;
    conversion_trigger = 1'b1;
    t = 0;
    while (converting !== 1'b1 && t < 10) begin
      cycles(1);
      t++;
    end
    chk1("converting", 1'b1, converting);
    chk1("sw_pos_open", 1'b0, positive_input_ground_switch);
    chk1("sw_neg_open", 1'b0, negative_input_ground_switch);
    chk1("array_late", 1'b0, array_to_ground);
    chk1("awake", 1'b0, powered_down);
    cycles(1);
    live_value = val ^ 18'h15555;
    if (bounce) begin
      conversion_trigger = 1'b0;
      cycles(4);
      conversion_trigger = 1'b1;
    end
    // The serial clock stays still throughout the conversion.
    while (result_ready !== 1'b1 && t < sar_pkg::FAST_PERIOD_CYC) begin
      cycles(1);
      t++;
    end
    chk1("ready_in_budget", 1'b1, result_ready);
    chk18("result", exp, result_code);
    chk1("back_to_acq", 1'b0, converting);
    chk1("power_down", 1'b1, powered_down);
    chk1("sw_closed", 1'b1, positive_input_ground_switch);
    cycles(5);
    chk1("single_result", 1'b1, (n_ready - first) == 1);
    chk1("no_restart", 1'b0, converting);
  endtask

  task automatic read_bits(input logic [W-1:0] exp);
    cycles(4);
    chk1("oe_on", 1'b0, serial_result_oe_n);
    chk1("bit_msb", exp[W-1], serial_result_output);
    for (int i = W - 2; i >= -1; i--) begin
      sclk = 1'b1;
      cycles(4);
      sclk = 1'b0;
      cycles(6);
      if (i >= 0) chk1("bit", exp[i], serial_result_output);
      chk18("held_code", exp, result_code);
    end
    chk1("oe_off", 1'b1, serial_result_oe_n);
  endtask

  task automatic t_codes;
    vals = '{18'h00000, 18'h00001, 18'h3FFFF, 18'h1FFFF, 18'h20000,
             18'h20001};
    foreach (vals[i]) convert(vals[i], 1'b0, 1'b0, 1'b0, vals[i]);
    convert(18'h00000, 1'b1, 1'b0, 1'b0, sar_pkg::CODE_POS_MAX);
    convert(18'h3FFFF, 1'b0, 1'b1, 1'b0, sar_pkg::CODE_NEG_MIN);
    $display("test codes done");
  endtask

  task automatic t_ignore;
    convert(18'h0A5A5, 1'b0, 1'b0, 1'b1, 18'h0A5A5);
    $display("test ignore done");
  endtask

  task automatic t_read_select;
    mode_select_chain_input = 1'b1;
    convert(18'h2C3A1, 1'b0, 1'b0, 1'b0, 18'h2C3A1);
    chk1("mode_select", 1'b0, chain_mode);
    conversion_trigger = 1'b0;
    read_bits(18'h2C3A1);
    $display("test read select done");
  endtask

  // Four-wire select mode: trigger stays high, the mode pin enables.
  task automatic t_read_four;
    mode_select_chain_input = 1'b1;
    convert(18'h0F0F3, 1'b0, 1'b0, 1'b0, 18'h0F0F3);
    chk1("oe_idle", 1'b1, serial_result_oe_n);
    mode_select_chain_input = 1'b0;
    read_bits(18'h0F0F3);
    mode_select_chain_input = 1'b1;
    $display("test read four wire done");
  endtask

  task automatic t_read_chain;
    mode_select_chain_input = 1'b0;
    convert(18'h1B64E, 1'b0, 1'b0, 1'b0, 18'h1B64E);
    chk1("mode_chain", 1'b1, chain_mode);
    read_bits(18'h1B64E);
    mode_select_chain_input = 1'b1;
    $display("test read chain done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (WDOG_CYC) @(posedge clk);
    n_errors++;
    $display("[ERR] watchdog expected done seen hang");
    finish_test();
  end

  initial begin
    n_errors = 0;
    compares = 0;
    n_ready = 0;
    nrst = 1'b0;
    conversion_trigger = 1'b0;
    mode_select_chain_input = 1'b1;
    sclk = 1'b0;
    live_value = '0;
    live_over = 1'b0;
    live_under = 1'b0;
    cycles(12);
    chk1("rst_power_down", 1'b1, powered_down);
    chk1("rst_sw", 1'b1, positive_input_ground_switch);
    chk1("rst_oe", 1'b1, serial_result_oe_n);
    chk18("rst_code", sar_pkg::RESULT_RESET, result_code);
    nrst = 1'b1;
    cycles(2);
    $display("test reset done");
    t_codes();
    t_ignore();
    t_read_select();
    t_read_four();
    t_read_chain();
    finish_test();
  end
endmodule
